// ===== design/xfer_bus_pkg.sv
// package for the shared transfer bus master controller
// assumes one 250 MHz clock and an interlocked, clockless bus outside
package xfer_bus_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W   = 23;             // addr_lines, word address bits 1..23
  localparam int QUAL_W   = 8;              // addr_qualifier_lines
  localparam int DATA_W   = 32;             // full data bus

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 4000;    // 250 MHz clock
  localparam int ADDR_SETUP_NS   = 8;       // address valid before strobe low
  localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_REL_NS   = 8;       // strobe driven high before release
  localparam int STROBE_REL_CYC  = (STROBE_REL_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [3:0] CNT_ZERO = 4'h0;   // timer idle value

  // ---------------------------------------------------------------
  // transfer widths requested by the user side
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,                         // one byte, chosen by addr bit 0
    SZ_WORD = 2'h1,                         // sixteen bits
    SZ_LONG = 2'h2                          // thirty-two bits
  } xfer_size_t;

  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE    = 9'b0_0000_0001,            // bus not owned
    ST_WAITBUS = 9'b0_0000_0010,            // granted, waiting for old owner
    ST_OWN     = 9'b0_0000_0100,            // bus owned, no cycle
    ST_ADDR    = 9'b0_0000_1000,            // address out, setup count
    ST_ASLOW   = 9'b0_0001_0000,            // strobe low, wait for ack lines high
    ST_DATA    = 9'b0_0010_0000,            // data strobes low, wait answer
    ST_TERM    = 9'b0_0100_0000,            // strobes driven high
    ST_ENDWAIT = 9'b0_1000_0000,            // wait slave to free ack lines
    ST_RELEASE = 9'b1_0000_0000             // strobe driven high, then released
  } ms_state_t;

endpackage

// ===== design/pin_sync.sv
// two-flop synchroniser for a group of bus pins
// assumes the pins are asynchronous to clk_i
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1                       // number of pins
) (
  input  wire logic         clk_i,          // system clock
  input  wire logic         arst_n_i,       // async reset, active low
  input  wire logic [W-1:0] d_i,            // raw pin levels
  output logic      [W-1:0] q_o             // synchronised levels
);

  // ---------------------------------------------------------------
  // two stages; reset to released (high) level
  // ---------------------------------------------------------------
  logic [W-1:0] meta;                       // first stage, read only by q_o

  // both stages run every edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= '1;
      q_o  <= '1;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ===== design/xfer_bus_master.sv
// master end of the shared transfer bus: ownership, address, data cycles
// assumes a requester/arbiter outside; pins are split into in/out/enable
// Summary of operation
// - obtain bus through requester before transfers
// - address, qualifier, width valid before strobe
// - direction high for reads before data strobe
// - ack and fault high before data strobes
// - odd byte read: odd strobe, low byte
// - on ack capture, release address, raise strobes
// - word write: direction low, both strobes
// - give up bus only after strobe low, or at once from OWN when leaving with no cycle
// - early release drops bus held line
// - new owner waits address free, strobe high
// - release others first, strobe high, release
// - unlimited back-to-back cycles while owned
// - optional address parity with address
// - odd strobe low byte, even strobe high
// - long transfer only four-byte aligned
`timescale 1ns/1ps
module xfer_bus_master
  import xfer_bus_pkg::*;
#(
  parameter bit PARITY_EN = 1'b1            // generate address parity
) (
  input  wire logic              clk_i,            // system clock
  input  wire logic              arst_n_i,         // async reset, active low
  // user side
  input  wire logic              own_req_i,        // want the bus (level)
  input  wire logic              cmd_valid_i,      // transfer request
  output logic                   cmd_ready_o,      // request taken this cycle
  input  wire logic              cmd_write_i,      // 1 write, 0 read
  input  wire xfer_size_t        cmd_size_i,       // byte, word, long
  input  wire logic [ADDR_W:0]   cmd_addr_i,       // byte address, bit 0 included
  input  wire logic [QUAL_W-1:0] cmd_qual_i,       // address qualifier code
  input  wire logic [DATA_W-1:0] cmd_wdata_i,      // write data, low lanes first
  input  wire logic              cmd_last_i,       // final cycle of this tenure
  output logic                   rsp_valid_o,      // one-cycle answer pulse
  output logic                   rsp_fault_o,      // answer was bus fault or bad request
  output logic [DATA_W-1:0]      rsp_rdata_o,      // captured read data
  output logic                   owned_o,          // bus owned (level)
  // requester side
  output logic                   bus_req_o,        // ask requester for the bus
  input  wire logic              bus_grant_i,      // requester says proceed
  input  wire logic              clear_req_i,      // arbiter asks to clear bus
  // bus pins; strobes, handshake and control lines active low on the wire, address and data lines not
  input  wire logic              addr_strobe_n_i,  // strobe level seen on bus
  output logic                   addr_strobe_n_o,  // strobe drive level
  output logic                   addr_strobe_oe_o, // strobe driven
  input  wire logic              addr_busy_i,      // someone drives address lines
  output logic [ADDR_W-1:0]      addr_lines_o,     // address bits 1..23
  output logic [QUAL_W-1:0]      addr_qualifier_lines_o, // qualifier code
  output logic                   addr_parity_n_o,  // address parity
  output logic                   wide_select_n_o,  // low for 32-bit transfer
  output logic                   write_n_o,        // low write, high read
  output logic                   ctl_oe_o,         // enable for address/control group
  output logic                   odd_byte_strobe_n_o,  // strobe for bits 0..7
  output logic                   even_byte_strobe_n_o, // strobe for bits 8..15
  output logic                   dstrobe_oe_o,     // data strobes driven
  input  wire logic [DATA_W-1:0] data_i,           // data lines seen
  output logic [DATA_W-1:0]      data_o,           // data lines driven
  output logic                   data_oe_o,        // data lines driven
  input  wire logic              transfer_ack_n_i, // slave ack
  input  wire logic              bus_fault_n_i     // slave fault
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] raw_pins;                     // async pins
  logic [4:0] syn_pins;                     // synchronised pins
  assign raw_pins = {addr_strobe_n_i, addr_busy_i, transfer_ack_n_i,
                     bus_fault_n_i, bus_grant_i};

  pin_sync #(.W(5)) u_sync (
    .clk_i   (clk_i),
    .arst_n_i(arst_n_i),
    .d_i     (raw_pins),
    .q_o     (syn_pins)
  );

  logic as_high, addr_busy, ack_n, fault_n, grant;  // synced levels
  assign as_high   = syn_pins[4];
  assign addr_busy = ~syn_pins[3];          // sync resets high; busy shown low
  assign ack_n     = syn_pins[2];
  assign fault_n   = syn_pins[1];
  assign grant     = ~syn_pins[0];          // grant pin active low on wire

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // odd parity over address and qualifier
  function automatic logic addr_par(input logic [ADDR_W-1:0] a,
                                    input logic [QUAL_W-1:0] q);
    addr_par = ~(^{a, q});
  endfunction

  // long access must sit on a four-byte boundary
  function automatic logic bad_req(input xfer_size_t s, input logic [ADDR_W:0] a);
    bad_req = (s == SZ_LONG) ? (a[1:0] != 2'b00) :
              (s == SZ_WORD) ? a[0] : 1'b0;
  endfunction

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  ms_state_t         state, next_state;     // controller state
  logic [3:0]        cnt;                   // setup/release timer
  logic              last_q;                // final cycle flag
  logic              write_q;               // latched direction
  xfer_size_t        size_q;                // latched width
  logic              odd_q;                 // byte address bit 0
  logic              req_q;                 // requester request

  // decoded conditions
  wire take     = (state == ST_OWN) && cmd_valid_i;           // command taken
  wire take_bad = take && bad_req(cmd_size_i, cmd_addr_i);    // refused at once
  wire lines_ok = ack_n && fault_n;                           // previous slave gone
  wire answered = !ack_n || !fault_n;                         // slave answered
  wire bus_free = !addr_busy && as_high;                      // old owner gone
  wire leave    = !own_req_i || clear_req_i;                  // give up bus

  assign cmd_ready_o = take;
  assign owned_o     = (state != ST_IDLE) && (state != ST_WAITBUS);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:    if (own_req_i && grant) next_state = ST_WAITBUS;
      ST_WAITBUS: if (bus_free) next_state = ST_OWN;
      ST_OWN: begin
        if (take && !take_bad) next_state = ST_ADDR;
        else if (leave) next_state = ST_RELEASE;
      end
      ST_ADDR:    if (cnt == CNT_ZERO) next_state = ST_ASLOW;
      ST_ASLOW:   if (lines_ok) next_state = ST_DATA;
      ST_DATA:    if (answered) next_state = ST_TERM;
      ST_TERM:    next_state = ST_ENDWAIT;
      ST_ENDWAIT: begin
        if (lines_ok) next_state = (last_q || clear_req_i) ? ST_RELEASE : ST_OWN;
      end
      ST_RELEASE: if (cnt == CNT_ZERO) next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) state <= ST_IDLE;
    else           state <= next_state;
  end

  // ---------------------------------------------------------------
  // timer: setup before strobe, drive-high time before release
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= CNT_ZERO;
    end else if (take) begin
      cnt <= 4'(ADDR_SETUP_CYC - 1);
    end else if (next_state == ST_RELEASE && state != ST_RELEASE) begin
      cnt <= 4'(STROBE_REL_CYC - 1);
    end else if (cnt != CNT_ZERO) begin
      cnt <= cnt - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // requester request: dropped early once strobe is low on last cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) req_q <= 1'b0;
    else if (state == ST_IDLE) req_q <= own_req_i;
    else if (state == ST_ASLOW && last_q) req_q <= 1'b0;
    else if (state == ST_OWN && leave) req_q <= 1'b0;
  end
  assign bus_req_o = req_q;

  // ---------------------------------------------------------------
  // latched command and address pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q  <= 1'b0;
      write_q <= 1'b0;
      size_q  <= SZ_BYTE;
      odd_q   <= 1'b0;
      addr_lines_o           <= '0;
      addr_qualifier_lines_o <= '0;
      addr_parity_n_o        <= 1'b1;
      wide_select_n_o        <= 1'b1;
      data_o                 <= '0;
    end else if (take) begin
      last_q  <= cmd_last_i;
      write_q <= cmd_write_i;
      size_q  <= cmd_size_i;
      odd_q   <= cmd_addr_i[0];
      addr_lines_o           <= cmd_addr_i[ADDR_W:1];
      addr_qualifier_lines_o <= cmd_qual_i;
      addr_parity_n_o        <= PARITY_EN ?
                                addr_par(cmd_addr_i[ADDR_W:1], cmd_qual_i) : 1'b1;
      wide_select_n_o        <= (cmd_size_i != SZ_LONG);
      // odd byte rides low lanes, even byte the next lane up
      data_o <= (cmd_size_i == SZ_BYTE && !cmd_addr_i[0]) ?
                {cmd_wdata_i[DATA_W-9:0], 8'h00} : cmd_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // pin drive: address group driven from ADDR to DATA only
  // ---------------------------------------------------------------
  wire in_cycle  = (state == ST_ADDR) || (state == ST_ASLOW) || (state == ST_DATA);
  wire strobe_lo = (state == ST_ASLOW) || (state == ST_DATA);
  wire ds_lo     = (state == ST_DATA);

  assign ctl_oe_o         = in_cycle;
  assign write_n_o        = !write_q;
  assign data_oe_o        = in_cycle && write_q;
  assign addr_strobe_n_o  = !strobe_lo;
  assign addr_strobe_oe_o = owned_o && (state != ST_WAITBUS) &&
                            !(state == ST_RELEASE && cnt == CNT_ZERO);
  assign dstrobe_oe_o     = in_cycle || (state == ST_TERM);

  // byte select: odd strobe for low byte, even strobe for next lane
  wire want_odd  = (size_q != SZ_BYTE) || odd_q;
  wire want_even = (size_q != SZ_BYTE) || !odd_q;
  assign odd_byte_strobe_n_o  = !(ds_lo && want_odd);
  assign even_byte_strobe_n_o = !(ds_lo && want_even);

  // ---------------------------------------------------------------
  // answer capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_fault_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= (state == ST_DATA && answered) || take_bad;
      if (take_bad) begin
        rsp_fault_o <= 1'b1;
      end else if (state == ST_DATA && answered) begin
        rsp_fault_o <= !fault_n;
        rsp_rdata_o <= data_i;
      end
    end
  end

endmodule

// ===== dv/xfer_bus_master_properties.sv
// port checker for the transfer bus master
// assumes bind into xfer_bus_master and its single clock domain
`timescale 1ns/1ps
module xfer_bus_master_chk
  import xfer_bus_pkg::*;
(
  input wire logic              clk_i, arst_n_i, own_req_i, clear_req_i, // clock, user
  input wire logic              bus_grant_i, bus_req_o, owned_o,        // ownership
  input wire logic              addr_busy_i, addr_strobe_n_i,           // bus seen
  input wire logic              addr_strobe_n_o, addr_strobe_oe_o,      // strobe drive
  input wire logic [ADDR_W-1:0] addr_lines_o,                           // address
  input wire logic [QUAL_W-1:0] addr_qualifier_lines_o,                 // qualifier
  input wire logic              addr_parity_n_o,                        // address parity
  input wire logic              wide_select_n_o, write_n_o, ctl_oe_o,   // control
  input wire logic              odd_byte_strobe_n_o, even_byte_strobe_n_o, // strobes
  input wire logic              dstrobe_oe_o, data_oe_o, rsp_valid_o,   // drives, answer
  input wire logic              transfer_ack_n_i, bus_fault_n_i         // slave answer
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire ds_hi = odd_byte_strobe_n_o && even_byte_strobe_n_o; // no data strobe low

  property p_addr_setup;
    addr_strobe_oe_o && $fell(addr_strobe_n_o) |-> $past(ctl_oe_o, 2) &&
      $stable(addr_lines_o) && $stable(addr_qualifier_lines_o) && $stable(wide_select_n_o);
  endproperty
  a_addr_setup: assert property (p_addr_setup) else $error("strobe fell on moving address");
  property p_ds_gate;
    dstrobe_oe_o && ($fell(odd_byte_strobe_n_o) || $fell(even_byte_strobe_n_o)) |->
      !addr_strobe_n_o && $stable(write_n_o) && $past(transfer_ack_n_i, 3) &&
      $past(bus_fault_n_i, 3);
  endproperty
  a_ds_gate: assert property (p_ds_gate) else $error("data strobe fell too early");
  property p_strobes;
    dstrobe_oe_o && !ds_hi |-> wide_select_n_o ||
      (!odd_byte_strobe_n_o && !even_byte_strobe_n_o && !addr_lines_o[0]);
  endproperty
  a_strobes: assert property (p_strobes) else $error("illegal strobe and width mix");
  property p_term;
    dstrobe_oe_o && $fell(transfer_ack_n_i && bus_fault_n_i) |->
      ##[1:6] (ds_hi && addr_strobe_n_o) ##[0:2] rsp_valid_o;
  endproperty
  a_term: assert property (p_term) else $error("cycle not ended after answer");
  property p_release;
    $fell(addr_strobe_oe_o) |-> $past(addr_strobe_n_o) && $past(addr_strobe_n_o, 2) &&
      !$past(ctl_oe_o) && !$past(data_oe_o) && !$past(dstrobe_oe_o);
  endproperty
  a_release: assert property (p_release) else $error("strobe released out of order");
  property p_early;
    $fell(bus_req_o) |-> !addr_strobe_n_o || !$past(own_req_i) || $past(clear_req_i);
  endproperty
  a_early: assert property (p_early) else $error("request dropped before strobe low");
  property p_own;
    $rose(owned_o) |-> $past(addr_busy_i, 3) && $past(addr_strobe_n_i, 3) &&
      !$past(bus_grant_i, 3) && !$past(ctl_oe_o);
  endproperty
  a_own: assert property (p_own) else $error("bus taken while still busy");
  property p_data_dir;
    data_oe_o |-> !write_n_o && ctl_oe_o;
  endproperty
  a_data_dir: assert property (p_data_dir) else $error("data driven on a read");
  // odd count of ones over parity, address and qualifier while strobe is low
  property p_parity;
    !addr_strobe_n_o |-> (^{addr_parity_n_o, addr_lines_o, addr_qualifier_lines_o}) == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("address parity wrong");
  c_long_write: cover property (dstrobe_oe_o && !wide_select_n_o && !write_n_o);
  c_fault: cover property (rsp_valid_o && !bus_fault_n_i);
  c_early: cover property ($fell(bus_req_o) && !addr_strobe_n_o);
endmodule
bind xfer_bus_master xfer_bus_master_chk u_chk (.*);

// ===== dv/xfer_slave_model.sv
// behavioural responding module on the transfer bus
// assumes strobe inputs already show pull-up levels when released
`timescale 1ns/1ps
module xfer_slave_model
  import xfer_bus_pkg::*;
#(
  parameter logic [18:0] BASE = 19'h0_0000, // decoded upper address
  parameter logic [7:0]  QUAL = 8'h3d       // accepted qualifier
) (
  input  wire logic              addr_strobe_n_i,        // address strobe
  input  wire logic [ADDR_W-1:0] addr_lines_i,           // address bits 1..23
  input  wire logic [QUAL_W-1:0] addr_qualifier_lines_i, // qualifier
  input  wire logic              wide_select_n_i,        // low for 32 bits
  input  wire logic              write_n_i,              // low write
  input  wire logic              odd_byte_strobe_n_i,    // lanes 7:0
  input  wire logic              even_byte_strobe_n_i,   // lanes 15:8
  input  wire logic [DATA_W-1:0] data_i,                 // data wire
  input  wire logic              bad_par_i,              // parity error ordered
  input  wire logic              slow_i,                 // answer slowly
  output logic      [DATA_W-1:0] data_o,                 // read data drive
  output logic                   drv_o,                  // data driven
  output logic                   transfer_ack_n_o,       // ack, released high
  output logic                   bus_fault_n_o           // fault, released high
);
  logic [15:0] mem [16]; // halfword store
  logic [3:0]  ix;       // halfword index
  // one bus cycle per loop
  initial begin
    data_o = 32'h0000_0000;
    {drv_o, transfer_ack_n_o, bus_fault_n_o} = 3'b011;
    forever begin
      @(negedge addr_strobe_n_i);
      ix = addr_lines_i[3:0];
      if (addr_lines_i[22:4] != BASE || addr_qualifier_lines_i != QUAL) continue;
      wait (!odd_byte_strobe_n_i || !even_byte_strobe_n_i);
      #(slow_i ? 62 : 6); // both land on a falling clock edge
      if (bad_par_i || (!wide_select_n_i && (ix[0] || odd_byte_strobe_n_i ||
          even_byte_strobe_n_i))) begin
        bus_fault_n_o = 1'b0;
      end else if (!write_n_i) begin
        if (!odd_byte_strobe_n_i) mem[ix][7:0] = data_i[7:0];
        if (!even_byte_strobe_n_i) mem[ix][15:8] = data_i[15:8];
        if (!wide_select_n_i) mem[ix | 4'h1] = data_i[31:16];
        transfer_ack_n_o = 1'b0;
      end else begin
        data_o = {mem[ix | 4'h1], mem[ix]};
        drv_o = 1'b1;
        #4 transfer_ack_n_o = 1'b0;
      end
      wait (odd_byte_strobe_n_i && even_byte_strobe_n_i);
      #3 drv_o = 1'b0;
      data_o = ~data_o; // released lines float away from the last value
      #3 {transfer_ack_n_o, bus_fault_n_o} = 2'b11;
    end
  end
endmodule

// ===== dv/async_transfer_bus_handshake_tb.sv
// self-checking bench: master against the behavioural slave
// assumes package, master, slave model and checker compiled first
`timescale 1ns/1ps
module async_transfer_bus_handshake_tb;
  import xfer_bus_pkg::*;
  localparam logic [7:0] QCODE = 8'h3d; // qualifier the slave accepts
  logic clk_i, arst_n_i, own_req_i, cmd_valid_i, cmd_ready_o, cmd_write_i, cmd_last_i;
  logic rsp_valid_o, rsp_fault_o, owned_o, bus_req_o, bus_grant_i, clear_req_i, s_drv;
  logic addr_strobe_n_i, addr_strobe_n_o, addr_strobe_oe_o, addr_busy_i, addr_parity_n_o;
  logic wide_select_n_o, write_n_o, ctl_oe_o, dstrobe_oe_o, data_oe_o, other_drv, slow;
  logic odd_byte_strobe_n_o, even_byte_strobe_n_o, transfer_ack_n_i, bus_fault_n_i, bad_par;
  xfer_size_t        cmd_size_i;
  logic [ADDR_W:0]   cmd_addr_i;
  logic [ADDR_W-1:0] addr_lines_o;
  logic [QUAL_W-1:0] cmd_qual_i, addr_qualifier_lines_o;
  logic [DATA_W-1:0] cmd_wdata_i, rsp_rdata_o, data_i, data_o, s_data;
  logic [64:0]       exq[$];  // expected {fault, lane mask, data}
  int                fail_count, cmp_count, seed;
  // wire levels: pull-up on strobe, busy low while anyone drives
  assign addr_strobe_n_i = addr_strobe_n_o | ~addr_strobe_oe_o;
  assign addr_busy_i     = ~(ctl_oe_o | other_drv);
  assign data_i          = data_oe_o ? data_o : s_data;
  xfer_bus_master dut (.*);
  xfer_slave_model #(.QUAL(QCODE)) slave (.addr_strobe_n_i(addr_strobe_n_i),
    .addr_lines_i(addr_lines_o), .addr_qualifier_lines_i(addr_qualifier_lines_o),
    .wide_select_n_i(wide_select_n_o), .write_n_i(write_n_o), .data_i(data_i),
    .odd_byte_strobe_n_i(odd_byte_strobe_n_o | ~dstrobe_oe_o), .bad_par_i(bad_par),
    .even_byte_strobe_n_i(even_byte_strobe_n_o | ~dstrobe_oe_o), .slow_i(slow),
    .data_o(s_data), .drv_o(s_drv), .transfer_ack_n_o(transfer_ack_n_i),
    .bus_fault_n_o(bus_fault_n_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one command: request held until taken, expectation noted
  task automatic xfer(input logic w, input xfer_size_t sz, input logic [23:0] a,
                      input logic last, input logic [31:0] wd, input logic [64:0] e);
    @(posedge clk_i);
    {cmd_valid_i, cmd_write_i, cmd_last_i} <= {1'b1, w, last};
    cmd_size_i  <= sz;
    cmd_addr_i  <= a;
    cmd_wdata_i <= wd;
    exq.push_back(e);
    for (int n = 0; n < 400; n++) begin
      @(negedge clk_i);
      if (cmd_ready_o === 1'b1) break;
    end
    chk("cmd_ready_o", 32'h1, 32'(cmd_ready_o));
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask
  // answer watcher: oldest note against each answer pulse
  always @(negedge clk_i) begin
    logic [64:0] e;
    if (rsp_valid_o === 1'b1) begin
      e = (exq.size() > 0) ? exq.pop_front() : {1'b1, 64'h0};
      chk("rsp_fault", 32'(e[64]), 32'(rsp_fault_o));
      chk("rsp_rdata", e[31:0] & e[63:32], rsp_rdata_o & e[63:32]);
    end
  end
  initial begin
    #60000 fail_count++;
    conclude();
  end
  initial begin
    logic [31:0] wd, mask, ed;
    logic [23:0] a;
    xfer_size_t  sz;
    int          n;
    seed = 32'h4fa4_335a;
    {arst_n_i, own_req_i, cmd_valid_i, cmd_write_i, cmd_last_i, clear_req_i} = '0;
    {bad_par, slow, cmd_addr_i, cmd_wdata_i, bus_grant_i, other_drv} = '1;
    cmd_size_i = SZ_BYTE;
    cmd_qual_i = QCODE;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    {bad_par, slow} <= 2'b00;
    @(negedge clk_i);
    chk("idle drives", 32'h0, 32'({ctl_oe_o, data_oe_o, addr_strobe_oe_o, bus_req_o}));
    @(posedge clk_i);
    own_req_i <= 1'b1;
    for (n = 0; n < 50 && bus_req_o !== 1'b1; n++) @(negedge clk_i);
    @(posedge clk_i);
    bus_grant_i <= 1'b0;
    repeat (12) @(negedge clk_i);
    chk("owned_o", 32'h0, 32'(owned_o));
    @(posedge clk_i);
    other_drv <= 1'b0;
    for (n = 0; n < 50 && owned_o !== 1'b1; n++) @(negedge clk_i);
    chk("owned_o", 32'h1, 32'(owned_o));
    for (int k = 0; k < 12; k++) begin
      sz = xfer_size_t'(k % 3);
      wd = $random(seed);
      a = {19'h0, wd[4:2], wd[1] & (sz != SZ_LONG), (sz == SZ_BYTE) & k[1]};
      slow <= k[0];
      mask = sz == SZ_LONG ? 32'hffff_ffff : sz == SZ_WORD ? 32'h0000_ffff :
             a[0] ? 32'h0000_00ff : 32'h0000_ff00;
      ed = (sz == SZ_BYTE && !a[0]) ? {16'h0, wd[7:0], 8'h0} : wd;
      xfer(1'b1, sz, a, 1'b0, wd, 65'h0);
      xfer(1'b0, sz, a, 1'b0, wd, {1'b0, mask, ed});
    end
    xfer(1'b0, SZ_WORD, 24'h00_0003, 1'b0, 32'h0, {1'b1, 64'h0});
    xfer(1'b0, SZ_LONG, 24'h00_0006, 1'b0, 32'h0, {1'b1, 64'h0});
    bad_par <= 1'b1;
    xfer(1'b1, SZ_WORD, 24'h00_0008, 1'b0, 32'h0, {1'b1, 64'h0});
    for (n = 0; n < 300 && exq.size() > 0; n++) @(negedge clk_i);
    @(posedge clk_i);
    bad_par <= 1'b0;
    xfer(1'b1, SZ_WORD, 24'h00_0010, 1'b1, wd, 65'h0);
    own_req_i <= 1'b0;
    for (n = 0; n < 300 && (exq.size() > 0 || owned_o !== 1'b0); n++) @(negedge clk_i);
    chk("pending", 32'h0, 32'(exq.size()));
    chk("bus_req_o", 32'h0, 32'(bus_req_o));
    repeat (6) @(negedge clk_i);
    chk("release", 32'h0, 32'({addr_strobe_oe_o, ctl_oe_o, dstrobe_oe_o}));
    // second tenure, ended by the arbiter withdrawing grant and asking to clear
    @(posedge clk_i);
    own_req_i <= 1'b1;
    for (n = 0; n < 50 && owned_o !== 1'b1; n++) @(negedge clk_i);
    chk("owned_o", 32'h1, 32'(owned_o));
    @(posedge clk_i);
    {bus_grant_i, clear_req_i} <= 2'b11;
    repeat (12) @(negedge clk_i);
    chk("clear", 32'h0, 32'({owned_o, addr_strobe_oe_o, ctl_oe_o, dstrobe_oe_o}));
    conclude();
  end
endmodule
